//--- hdl/osc_ctrl_pkg.sv
// package for the internal oscillator control block: offsets, fields, resets, types
// assumes an 8-bit special-function register port on the system clock
package osc_ctrl_pkg;
  localparam logic [7:0] ADDR_CONTROL     = 8'hb2;
  localparam logic [7:0] ADDR_CALIBRATION = 8'hb3;
  localparam logic [7:0] ADDR_LOW_FREQ    = 8'hb4;
  localparam int         BIT_ENABLE       = 7;
  localparam int         BIT_READY        = 6;
  localparam int         BIT_STOP         = 5;
  localparam int         BIT_LF_ENABLE    = 7;
  localparam int         TRIM_W           = 5;
  localparam logic [7:0] CONTROL_RESET    = 8'hc0;
  localparam logic [7:0] LOW_FREQ_RESET   = 8'h00;
  localparam logic [1:0] DIV_BY_8         = 2'h0;
  localparam logic [1:0] DIV_BY_4         = 2'h1;
  localparam logic [1:0] DIV_BY_2         = 2'h2;
  localparam logic [1:0] DIV_BY_1         = 2'h3;
  localparam logic [2:0] DIV_MAX          = 3'h7;
  localparam logic [7:0] ZERO8            = 8'h00;
  // time in ns the oscillator takes to settle after a start or a trim change
  localparam int         SETTLE_NS        = 100;
  localparam int         CLK_NS           = 20;
  localparam logic [3:0] SETTLE_CYC       = 4'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    OSC_OFF     = 3'b001,
    OSC_SETTLE  = 3'b010,
    OSC_RUNNING = 3'b100
  } osc_state_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } sfr_req_type;

  typedef struct packed {
    logic [2:0]  cnt_r;
    logic        tick_r;
  } divider_state_type;
endpackage

//--- hdl/system_clock_divider.sv
// divides the oscillator-rate tick stream down to the system clock enable
// assumes osc_tick_i pulses once per oscillator period on the same clock
module system_clock_divider
  import osc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // control
  input  wire logic       osc_tick_i,
  input  wire logic [1:0] system_clock_divider_field_i,
  // output
  output logic            system_clock_o
);
  divider_state_type s_r;
  divider_state_type s_nxt;

  function automatic logic [2:0] div_limit(input logic [1:0] code);
    unique case (code)
      DIV_BY_8: div_limit = DIV_MAX;
      DIV_BY_4: div_limit = 3'h3;
      DIV_BY_2: div_limit = 3'h1;
      DIV_BY_1: div_limit = 3'h0;
    endcase
  endfunction

  always_comb begin
    s_nxt        = s_r;
    s_nxt.tick_r = 1'b0;
    if (osc_tick_i) begin
      if (s_r.cnt_r >= div_limit(system_clock_divider_field_i)) begin
        s_nxt.cnt_r  = 3'h0;
        s_nxt.tick_r = 1'b1;
      end else begin
        s_nxt.cnt_r = s_r.cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign system_clock_o = s_r.tick_r;
endmodule

//--- hdl/internal_osc_control.sv
// internal oscillator control: control, calibration and low-frequency registers,
// oscillator run state, forced stop with wake, and system clock divider
// assumes an 8-bit register port on the system clock and wake pins from outside
//
// Notes on behaviour
// - oscillator runs while enable bit is set
// - ready flag shows oscillator at programmed frequency
// - writing one to stop bit halts oscillator
// - usb activity or vbus event restarts oscillator
// - divider codes 01,10,11 divide four, two, one
// - code 00 divides eight, reset value
// - five-bit trim field sets oscillator period
// - trim reads undefined during clock recovery
// - reset reloads factory trim value
// - usb wake only with transceiver on/suspended
// - low-frequency oscillator follows its own enable bit
module internal_osc_control
  import osc_ctrl_pkg::*;
#(
  // factory trim loaded at every reset; value here is arbitrary
  parameter logic [TRIM_W-1:0] FACTORY_TRIM = 5'h10
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // register port
  input  wire sfr_req_type       sfr_req_i,
  output logic [7:0]             sfr_rdata_o,
  // wake sources and clock recovery status
  input  wire logic              usb_resume_i,
  input  wire logic              usb_xcvr_active_i,
  input  wire logic              vbus_event_i,
  input  wire logic              clock_recovery_i,
  // oscillator side
  input  wire logic              osc_tick_i,
  output logic                   osc_run_o,
  output logic [TRIM_W-1:0]      period_trim_field_o,
  output logic                   low_freq_osc_run_o,
  output logic                   system_clock_o
);
  typedef struct packed {
    osc_state_type       state_r;
    logic [3:0]          settle_r;
    logic                osc_enable_bit_r;
    logic                stopped_r;
    logic [1:0]          system_clock_divider_field_r;
    logic [TRIM_W-1:0]   period_trim_field_r;
    logic                lf_enable_r;
    logic [7:0]          rdata_r;
    logic [2:0]          usb_sync_r;
    logic [2:0]          xcvr_sync_r;
    logic [2:0]          vbus_sync_r;
    logic [2:0]          rec_sync_r;
  } ctrl_state_type;

  ctrl_state_type s_r;
  ctrl_state_type s_nxt;

  logic usb_wake;
  logic vbus_wake;
  logic osc_wanted;
  logic freq_ready_flag;

  function automatic logic sync_high(input logic [2:0] sync);
    sync_high = sync[2] & sync[1];
  endfunction

  function automatic logic is_write(input sfr_req_type req, input logic [7:0] addr);
    is_write = req.wr && (req.addr == addr);
  endfunction

  // only the second and third stages are looked at; the first is metastability fodder
  assign usb_wake        = sync_high(s_r.usb_sync_r) && sync_high(s_r.xcvr_sync_r);
  assign vbus_wake       = sync_high(s_r.vbus_sync_r);
  assign osc_wanted      = s_r.osc_enable_bit_r && !s_r.stopped_r;
  assign freq_ready_flag = (s_r.state_r == OSC_RUNNING);

  always_comb begin
    s_nxt             = s_r;
    s_nxt.usb_sync_r  = {s_r.usb_sync_r[1:0], usb_resume_i};
    s_nxt.xcvr_sync_r = {s_r.xcvr_sync_r[1:0], usb_xcvr_active_i};
    s_nxt.vbus_sync_r = {s_r.vbus_sync_r[1:0], vbus_event_i};
    s_nxt.rec_sync_r  = {s_r.rec_sync_r[1:0], clock_recovery_i};

    if (is_write(sfr_req_i, ADDR_CONTROL)) begin
      s_nxt.osc_enable_bit_r       = sfr_req_i.wdata[BIT_ENABLE];
      s_nxt.system_clock_divider_field_r = sfr_req_i.wdata[1:0];
      if (sfr_req_i.wdata[BIT_STOP]) begin
        s_nxt.stopped_r = 1'b1;
      end
    end
    // a wake in the same cycle as the stop write wins, so no event is lost
    if (s_r.stopped_r || is_write(sfr_req_i, ADDR_CONTROL)) begin
      if (usb_wake || vbus_wake) begin
        s_nxt.stopped_r = 1'b0;
      end
    end
    if (is_write(sfr_req_i, ADDR_CALIBRATION)) begin
      s_nxt.period_trim_field_r = sfr_req_i.wdata[TRIM_W-1:0];
    end
    if (is_write(sfr_req_i, ADDR_LOW_FREQ)) begin
      s_nxt.lf_enable_r = sfr_req_i.wdata[BIT_LF_ENABLE];
    end

    unique case (s_r.state_r)
      OSC_OFF: begin
        if (osc_wanted) begin
          s_nxt.state_r  = OSC_SETTLE;
          s_nxt.settle_r = SETTLE_CYC;
        end
      end
      OSC_SETTLE: begin
        if (!osc_wanted) begin
          s_nxt.state_r = OSC_OFF;
        end else if (s_r.settle_r <= 4'h1) begin
          s_nxt.state_r = OSC_RUNNING;
        end else begin
          s_nxt.settle_r = s_r.settle_r - 4'h1;
        end
      end
      OSC_RUNNING: begin
        if (!osc_wanted) begin
          s_nxt.state_r = OSC_OFF;
        end else if (is_write(sfr_req_i, ADDR_CALIBRATION)) begin
          // a new trim moves the frequency, so ready drops until it settles
          s_nxt.state_r  = OSC_SETTLE;
          s_nxt.settle_r = SETTLE_CYC;
        end
      end
      default: begin
        s_nxt.state_r = OSC_OFF;
      end
    endcase

    s_nxt.rdata_r = ZERO8;
    if (sfr_req_i.rd) begin
      unique case (sfr_req_i.addr)
        ADDR_CONTROL: begin
          s_nxt.rdata_r[BIT_ENABLE] = s_r.osc_enable_bit_r;
          s_nxt.rdata_r[BIT_READY]  = freq_ready_flag;
          s_nxt.rdata_r[1:0]        = s_r.system_clock_divider_field_r;
        end
        ADDR_CALIBRATION: begin
          // under clock recovery the trim is live-adjusted; value shown is not meaningful
          if (!sync_high(s_r.rec_sync_r)) begin
            s_nxt.rdata_r[TRIM_W-1:0] = s_r.period_trim_field_r;
          end
        end
        ADDR_LOW_FREQ: begin
          s_nxt.rdata_r[BIT_LF_ENABLE] = s_r.lf_enable_r;
        end
        default: begin
          s_nxt.rdata_r = ZERO8;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r                        <= '0;
      s_r.state_r                <= OSC_SETTLE;
      s_r.settle_r               <= SETTLE_CYC;
      s_r.osc_enable_bit_r       <= CONTROL_RESET[BIT_ENABLE];
      s_r.system_clock_divider_field_r <= DIV_BY_8;
      s_r.period_trim_field_r    <= FACTORY_TRIM;
      s_r.lf_enable_r            <= LOW_FREQ_RESET[BIT_LF_ENABLE];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sfr_rdata_o         = s_r.rdata_r;
  assign osc_run_o           = (s_r.state_r != OSC_OFF);
  assign period_trim_field_o = s_r.period_trim_field_r;
  assign low_freq_osc_run_o  = s_r.lf_enable_r;

  system_clock_divider u_div (
    .clk_i                  (clk_i),
    .resetn_i               (resetn_i),
    .osc_tick_i             (osc_tick_i && osc_run_o),
    .system_clock_divider_field_i (s_r.system_clock_divider_field_r),
    .system_clock_o         (system_clock_o)
  );
endmodule

//--- verification/osc_ctrl_monitor.sv
// concurrent checks on the internal oscillator control block
// sees only the top module's ports; bound in below, one clock domain
module osc_ctrl_monitor
  import osc_ctrl_pkg::*;
#(
  parameter logic [TRIM_W-1:0] FACTORY_TRIM = 5'h10
) (
  // clock and reset
  input wire logic              clk_i,
  input wire logic              resetn_i,
  // register port
  input wire sfr_req_type       sfr_req_i,
  input wire logic [7:0]        sfr_rdata_o,
  // wake sources
  input wire logic              usb_resume_i,
  input wire logic              vbus_event_i,
  // oscillator side
  input wire logic              osc_run_o,
  input wire logic [TRIM_W-1:0] period_trim_field_o,
  input wire logic              low_freq_osc_run_o,
  input wire logic              system_clock_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic ctl_wr;
  logic ctl_rd;
  assign ctl_wr = sfr_req_i.wr && sfr_req_i.addr == ADDR_CONTROL;
  assign ctl_rd = sfr_req_i.rd && sfr_req_i.addr == ADDR_CONTROL;

  enable_off_a: assert property (ctl_wr && !sfr_req_i.wdata[BIT_ENABLE] |-> ##2 !osc_run_o)
    else $error("oscillator still runs after disable");
  // a wake already in the synchroniser would win, so only quiet pins count
  stop_write_a: assert property (ctl_wr && sfr_req_i.wdata[BIT_STOP] && !vbus_event_i
    && !usb_resume_i |-> ##2 !osc_run_o)
    else $error("oscillator still runs after stop");
  ctl_unused_a: assert property (ctl_rd |=> sfr_rdata_o[5:2] == 4'h0)
    else $error("control unused bits not zero");
  unmapped_read_a: assert property (sfr_req_i.rd
    && !(sfr_req_i.addr inside {[ADDR_CONTROL:ADDR_LOW_FREQ]}) |=> sfr_rdata_o == ZERO8)
    else $error("unmapped read not zero");
  trim_write_a: assert property (sfr_req_i.wr && sfr_req_i.addr == ADDR_CALIBRATION
    |=> period_trim_field_o == $past(sfr_req_i.wdata[TRIM_W-1:0]))
    else $error("trim field did not follow write");
  trim_reset_a: assert property ($rose(resetn_i) |-> period_trim_field_o == FACTORY_TRIM)
    else $error("trim not reloaded at reset");
  ready_low_a: assert property (ctl_rd && !osc_run_o |=> !sfr_rdata_o[BIT_READY])
    else $error("ready flag set while stopped");
  lf_write_a: assert property (sfr_req_i.wr && sfr_req_i.addr == ADDR_LOW_FREQ
    |=> low_freq_osc_run_o == $past(sfr_req_i.wdata[BIT_LF_ENABLE]))
    else $error("low frequency enable wrong");
  system_clock_stop_a: assert property (!osc_run_o [*3] |-> !system_clock_o)
    else $error("system clock while oscillator off");

  cover property (ctl_wr && sfr_req_i.wdata[BIT_STOP]);
  cover property ($rose(osc_run_o));
  cover property (system_clock_o);
endmodule

bind internal_osc_control osc_ctrl_monitor #(.FACTORY_TRIM(FACTORY_TRIM)) u_mon (
  .clk_i, .resetn_i, .sfr_req_i, .sfr_rdata_o, .usb_resume_i, .vbus_event_i,
  .osc_run_o, .period_trim_field_o, .low_freq_osc_run_o, .system_clock_o);

//--- verification/internal_osc_control_test.sv
// self-checking bench for the internal oscillator control block
// drives the register port and wake pins itself; ticks arrive every cycle
module internal_osc_control_test
  import osc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [TRIM_W-1:0] TRIM = 5'h0b;
  logic clk_i, resetn_i, usb_resume_i, usb_xcvr_active_i, vbus_event_i, clock_recovery_i;
  logic rd_seen = 0;
  logic osc_run_o, low_freq_osc_run_o, system_clock_o;
  sfr_req_type sfr_req_i;
  logic [7:0] sfr_rdata_o, r, exp_q[$];
  logic [TRIM_W-1:0] period_trim_field_o;
  int err_count = 0, check_count = 0, n, seed = 32'h0000_ece4;

  internal_osc_control #(.FACTORY_TRIM(TRIM)) dut (.clk_i, .resetn_i, .sfr_req_i,
    .sfr_rdata_o, .usb_resume_i, .usb_xcvr_active_i, .vbus_event_i,
    .clock_recovery_i, .osc_tick_i(1'b1), .osc_run_o, .period_trim_field_o,
    .low_freq_osc_run_o, .system_clock_o);

  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask

  task results();
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one strobe then an idle edge, so a strobe is never assigned twice per step
  task req(input logic w, input logic [7:0] a, input logic [7:0] d);
    sfr_req_i <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    sfr_req_i <= '0;
    @(posedge clk_i);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    req(1'b0, a, 8'h00);
  endtask

  task wait_run(input logic v);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (osc_run_o !== v && n < 30);
    check("osc run", 8'(osc_run_o), 8'(v));
    @(posedge clk_i);
  endtask

  // skip one pulse first: the count may be mid-way after a divider change
  task period(input logic [7:0] exp);
    repeat (2) begin
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (system_clock_o !== 1'b1 && n < 20);
    end
    check("system_clock period", 8'(n), exp);
    @(posedge clk_i);
  endtask

  always @(posedge clk_i) rd_seen <= sfr_req_i.rd;
  always @(negedge clk_i) begin
    if (rd_seen) check("read data", sfr_rdata_o, exp_q.pop_front());
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    results();
  end

  initial begin
    sfr_req_i = '0;
    resetn_i = 0;
    usb_resume_i = 0;
    usb_xcvr_active_i = 0;
    vbus_event_i = 0;
    clock_recovery_i = 0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1;
    repeat (8) @(posedge clk_i);
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_CALIBRATION, 8'(TRIM));
    period(8'h08);
    for (int c = 1; c < 4; c++) begin
      r = 8'($random(seed));
      req(1'b1, ADDR_CONTROL, {1'b1, r[6], 1'b0, r[4:2], 2'(c)});
      rd(ADDR_CONTROL, {6'h30, 2'(c)});
      period(8'h08 >> c);
    end
    r = 8'($random(seed));
    req(1'b1, ADDR_CALIBRATION, r);
    rd(ADDR_CALIBRATION, {3'h0, r[4:0]});
    req(1'b1, 8'hb5, 8'hff);
    rd(8'hb5, ZERO8);
    req(1'b1, ADDR_LOW_FREQ, 8'hff);
    check("lf run", 8'(low_freq_osc_run_o), 8'h01);
    rd(ADDR_LOW_FREQ, 8'h80);
    req(1'b1, ADDR_CONTROL, 8'ha3);
    rd(ADDR_CONTROL, 8'h83);
    vbus_event_i <= 1;
    wait_run(1'b1);
    vbus_event_i <= 0;
    repeat (8) @(posedge clk_i);
    rd(ADDR_CONTROL, 8'hc3);
    req(1'b1, ADDR_CONTROL, 8'ha3);
    usb_resume_i <= 1;
    repeat (12) @(negedge clk_i);
    check("osc run", 8'(osc_run_o), 8'h00);
    @(posedge clk_i);
    usb_xcvr_active_i <= 1;
    wait_run(1'b1);
    usb_resume_i <= 0;
    req(1'b1, ADDR_CONTROL, 8'h03);
    rd(ADDR_CONTROL, 8'h03);
    wait_run(1'b0);
    req(1'b1, ADDR_CONTROL, 8'h83);
    wait_run(1'b1);
    // recovery must pass the synchroniser before the read hides the trim
    clock_recovery_i <= 1;
    repeat (4) @(posedge clk_i);
    rd(ADDR_CALIBRATION, ZERO8);
    // a second reset after the trim and divider moved must restore both
    resetn_i <= 0;
    clock_recovery_i <= 0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1;
    repeat (8) @(posedge clk_i);
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_CALIBRATION, 8'(TRIM));
    check("trim out", 8'(period_trim_field_o), 8'(TRIM));
    check("lf run", 8'(low_freq_osc_run_o), 8'h00);
    period(8'h08);
    results();
  end
endmodule
